//--- dma_regs.vh
// register offsets, field positions and codes of the four-channel dma core
`ifndef DMA_REGS_VH
`define DMA_REGS_VH
`define OFF_SRC        2'h0
`define OFF_DST        2'h1
`define OFF_CNT        2'h2
`define OFF_CTL        2'h3
`define OFF_CH_TOP     2'h0
`define OFF_GLOBAL     8'h40
`define CTL_DE         0
`define CTL_TE         1
`define CTL_IE         2
`define CTL_TS         3
`define CTL_TM         5
`define CTL_DS         6
`define CTL_RS         8
`define CTL_SM         12
`define CTL_DM         14
`define CTL_IND        20
`define CTL_MASK       32'h0010FF7D
`define CTL_MASK_HI    32'h0010FF3D
`define GOC_DME        0
`define GOC_NMI        1
`define GOC_AE         2
`define GOC_PR         8
`define RS_DUAL        4'h0
`define RS_TO_ACK      4'h2
`define RS_FROM_ACK    4'h3
`define RS_AUTO        4'h4
`define RS_PERIPH      4'hA
`define RS_TIMER       4'hF
`define TS_BYTE        2'h0
`define TS_WORD        2'h1
`define TS_LONG        2'h2
`define TS_UNIT16      2'h3
`define AM_INC         2'h1
`define AM_DEC         2'h2
`define STEP_BYTE      32'h00000001
`define STEP_WORD      32'h00000002
`define STEP_LONG      32'h00000004
`define STEP_UNIT16    32'h00000010
`define PR_ROTATE      2'h3
`define ORDER_PR0      8'hE4
`define ORDER_PR1      8'h78
`define ORDER_PR2      8'hD2
`endif

//--- dma_core.v
// four-channel dma core: ahb-lite registers, request modes, arbitration, unit sequencing
`timescale 1ns/1ps
`include "dma_regs.vh"
module dma_core #(
	parameter CNT_W = 24,
	parameter NPER  = 6
) (
	input  wire              hclk,
	input  wire              hresetn,
	input  wire              hsel,
	input  wire [31:0]       haddr,
	input  wire [1:0]        htrans,
	input  wire              hwrite,
	input  wire [2:0]        hsize,
	input  wire [31:0]       hwdata,
	input  wire              hready,
	output reg               hreadyout,
	output reg               hresp,
	output reg  [31:0]       hrdata,
	input  wire              nmi_event,
	input  wire              addr_error,
	input  wire [1:0]        external_request_line_n,
	input  wire [NPER-1:0]   periph_req,
	output reg  [NPER-1:0]   periph_withdraw,
	output reg  [NPER-1:0]   periph_irq,
	output reg  [3:0]        transfer_end_interrupt,
	output reg               xfer_req,
	output reg               xfer_fetch,
	output reg  [1:0]        xfer_chan,
	output reg  [1:0]        xfer_size,
	output reg  [31:0]       xfer_src,
	output reg  [31:0]       xfer_dst,
	output reg               request_acknowledge_strobe,
	output reg               xfer_ack_to_device,
	input  wire              xfer_done,
	input  wire [31:0]       xfer_rdata
);
	localparam ST_IDLE = 2'h0;
	localparam ST_IND  = 2'h1;
	localparam ST_MOVE = 2'h2;

	reg  [1:0]       state_reg;
	reg  [1:0]       g_reg;
	reg  [7:0]       rot_reg;
	reg  [7:0]       rot_next;
	reg              master_enable;
	reg              nmi_flag;
	reg              addr_error_flag;
	reg  [1:0]       priority_select;
	reg              nmi_arm;
	reg              ae_arm;
	reg  [7:0]       a_addr;
	reg              rd_pend;
	reg              wr_pend;
	reg  [31:0]      rd_data;
	reg  [7:0]       order;
	reg              found;
	reg  [1:0]       pick;
	reg  [NPER-1:0]  consumed;
	integer          k;
	integer          j;
	integer          m;

	wire [127:0]     src_w;
	wire [127:0]     dst_w;
	wire [127:0]     srcn_w;
	wire [127:0]     dstn_w;
	wire [127:0]     ctl_w;
	wire [4*CNT_W-1:0] cnt_w;
	wire [3:0]       ok_w;
	wire [3:0]       req_w;
	wire [3:0]       burst_w;
	wire [4*NPER-1:0] psel_w;
	wire [3:0]       done_vec;
	wire [3:0]       start_vec;

	wire       ahb_ok  = hsel & hready & htrans[1];
	wire       ch_hit  = (a_addr[7:6] == `OFF_CH_TOP) && (a_addr[1:0] == 2'h0);
	wire [1:0] a_ch    = a_addr[5:4];
	wire [1:0] a_reg   = a_addr[3:2];
	wire       gl_hit  = (a_addr == `OFF_GLOBAL);
	wire       gl_wr   = wr_pend & gl_hit;
	wire       gl_rd   = rd_pend & gl_hit;
	wire [31:0] g_ctl  = ctl_w[g_reg*32 +: 32];
	wire [CNT_W-1:0] g_cnt = cnt_w[g_reg*CNT_W +: CNT_W];
	wire       g_last  = (g_cnt == {{(CNT_W-1){1'b0}}, 1'b1});
	wire       g_rs_p  = g_ctl[`CTL_RS+3 -: 4] >= `RS_PERIPH;
	wire [3:0] g_pidx  = g_ctl[`CTL_RS+3 -: 4] - `RS_PERIPH;
	// an abort seen in the same cycle as done still wins, so the end flag never sets
	wire       abort   = ~ok_w[g_reg] | nmi_event | addr_error;
	wire       busy    = (state_reg != ST_IDLE);
	wire       unit_end = (state_reg == ST_MOVE) & xfer_done & ~abort;
	wire       cont    = unit_end & burst_w[g_reg] & req_w[g_reg] & ~g_last;
	// an abort input in the grant cycle blocks the launch as well
	wire       launch  = (((state_reg == ST_IDLE) & found) | cont) & ~nmi_event & ~addr_error;
	wire [1:0] l_ch    = cont ? g_reg : pick;
	wire [31:0] l_ctl  = ctl_w[l_ch*32 +: 32];
	wire [3:0] l_rs    = l_ctl[`CTL_RS+3 -: 4];
	wire [3:0] l_pidx  = l_rs - `RS_PERIPH;

	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_ch
			reg  [31:0]      src_reg;
			reg  [31:0]      dst_reg;
			reg  [CNT_W-1:0] cnt_reg;
			reg  [31:0]      ctl_reg;
			reg              te_arm;
			reg              edge_pend;
			reg              line_prev;
			reg  [31:0]      step;
			reg              src_req;
			wire             line_n;
			wire [3:0]       rs   = ctl_reg[`CTL_RS+3 -: 4];
			wire [1:0]       ts   = ctl_reg[`CTL_TS+1 -: 2];
			wire [1:0]       sm   = ctl_reg[`CTL_SM+1 -: 2];
			wire [1:0]       dm   = ctl_reg[`CTL_DM+1 -: 2];
			wire             ind  = ctl_reg[`CTL_IND];
			wire [31:0]      sstep = ind ? `STEP_LONG : step;
			wire             is_p = (rs >= `RS_PERIPH);
			wire [3:0]       pidx = rs - `RS_PERIPH;
			wire             is_x = (rs == `RS_DUAL) | (rs == `RS_TO_ACK) | (rs == `RS_FROM_ACK);
			wire             wsel = wr_pend & ch_hit & (a_ch == i);
			wire             rsel = rd_pend & ch_hit & (a_ch == i) & (a_reg == `OFF_CTL);
			wire             fall = line_prev & ~line_n;
			wire [31:0]      mask = (i < 2) ? `CTL_MASK : `CTL_MASK_HI;
			wire             te_keep = ctl_reg[`CTL_TE] & ~(te_arm & ~hwdata[`CTL_TE]);
			// a burst relaunch needs these, as the registers only update on that edge
			wire [31:0]      src_nx = (sm == `AM_INC) ? src_reg + sstep :
				(sm == `AM_DEC) ? src_reg - sstep : src_reg;
			wire [31:0]      dst_nx = (dm == `AM_INC) ? dst_reg + step :
				(dm == `AM_DEC) ? dst_reg - step : dst_reg;
			if (i < 2) begin : g_ext
				assign line_n = external_request_line_n[i];
			end else begin : g_noext
				assign line_n = 1'b1;
			end
			always @* begin
				case (ts)
					`TS_BYTE: step = `STEP_BYTE;
					`TS_WORD: step = `STEP_WORD;
					`TS_LONG: step = `STEP_LONG;
					default:  step = `STEP_UNIT16;
				endcase
				src_req = 1'b0;
				if (rs == `RS_AUTO)
					src_req = 1'b1;
				else if (is_x && (i < 2))
					src_req = ctl_reg[`CTL_DS] ? edge_pend : ~line_n;
				else if (is_p)
					src_req = periph_req[pidx[2:0]];
			end
			// codes 0001 and 0101..1001 raise nothing, so unsupported pairings never start
			assign ok_w[i] = ctl_reg[`CTL_DE] & master_enable & ~ctl_reg[`CTL_TE]
				& ~addr_error_flag & ~nmi_flag;
			assign req_w[i] = ok_w[i] & src_req;
			assign burst_w[i] = ctl_reg[`CTL_TM] & (~is_p | (rs == `RS_TIMER));
			assign psel_w[i*NPER +: NPER] = (ctl_reg[`CTL_DE] & is_p) ?
				({{(NPER-1){1'b0}}, 1'b1} << pidx[2:0]) : {NPER{1'b0}};
			assign src_w[i*32 +: 32] = src_reg;
			assign dst_w[i*32 +: 32] = dst_reg;
			assign srcn_w[i*32 +: 32] = src_nx;
			assign dstn_w[i*32 +: 32] = dst_nx;
			assign cnt_w[i*CNT_W +: CNT_W] = cnt_reg;
			assign ctl_w[i*32 +: 32] = ctl_reg;
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					src_reg   <= 32'h00000000;
					dst_reg   <= 32'h00000000;
					cnt_reg   <= {CNT_W{1'b0}};
					ctl_reg   <= 32'h00000000;
					te_arm    <= 1'b0;
					edge_pend <= 1'b0;
					line_prev <= 1'b1;
				end else begin
					line_prev <= line_n;
					// an edge in the start cycle is kept, so a second pulse is not lost
					// only edge sensing latches, so level mode leaves no stale request
					if (fall && ctl_reg[`CTL_DS])
						edge_pend <= 1'b1;
					else if (start_vec[i])
						edge_pend <= 1'b0;
					if (wsel && a_reg == `OFF_SRC)
						src_reg <= hwdata;
					else if (done_vec[i])
						src_reg <= src_nx;
					if (wsel && a_reg == `OFF_DST)
						dst_reg <= hwdata;
					else if (done_vec[i])
						dst_reg <= dst_nx;
					if (wsel && a_reg == `OFF_CNT)
						cnt_reg <= hwdata[CNT_W-1:0];
					else if (done_vec[i])
						cnt_reg <= cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
					if (wsel && a_reg == `OFF_CTL) begin
						ctl_reg <= (hwdata & mask & ~(32'h1 << `CTL_TE))
							| ({31'h0, te_keep | (done_vec[i] & g_last)} << `CTL_TE);
					end else if (done_vec[i] && g_last) begin
						ctl_reg[`CTL_TE] <= 1'b1;
					end
					if (wsel && a_reg == `OFF_CTL)
						te_arm <= 1'b0;
					else if (rsel && ctl_reg[`CTL_TE])
						te_arm <= 1'b1;
				end
			end
			assign done_vec[i]  = unit_end & (g_reg == i);
			assign start_vec[i] = launch & (l_ch == i);
		end
	endgenerate

	always @* begin
		case (priority_select)
			2'h0:      order = `ORDER_PR0;
			2'h1:      order = `ORDER_PR1;
			2'h2:      order = `ORDER_PR2;
			default:   order = rot_reg;
		endcase
		found = 1'b0;
		pick  = 2'h0;
		for (k = 3; k >= 0; k = k - 1) begin
			if (req_w[order[k*2 +: 2]]) begin
				found = 1'b1;
				pick  = order[k*2 +: 2];
			end
		end
		rot_next = rot_reg;
		j = 0;
		for (k = 0; k < 4; k = k + 1) begin
			if (rot_reg[k*2 +: 2] != g_reg) begin
				rot_next[j*2 +: 2] = rot_reg[k*2 +: 2];
				j = j + 1;
			end
		end
		rot_next[7:6] = g_reg;
		consumed = {NPER{1'b0}};
		for (k = 0; k < 4; k = k + 1)
			consumed = consumed | psel_w[k*NPER +: NPER];
		rd_data = 32'h00000000;
		if (gl_hit) begin
			rd_data[`GOC_PR+1 -: 2] = priority_select;
			rd_data[`GOC_AE]  = addr_error_flag;
			rd_data[`GOC_NMI] = nmi_flag;
			rd_data[`GOC_DME] = master_enable;
		end else if (ch_hit) begin
			case (a_reg)
				`OFF_SRC: rd_data = src_w[a_ch*32 +: 32];
				`OFF_DST: rd_data = dst_w[a_ch*32 +: 32];
				`OFF_CNT: rd_data[CNT_W-1:0] = cnt_w[a_ch*CNT_W +: CNT_W];
				default:  rd_data = ctl_w[a_ch*32 +: 32];
			endcase
		end
	end

	// reads take one wait state so a read right after a write sees the new value
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h00000000;
			a_addr    <= 8'h00;
			rd_pend   <= 1'b0;
			wr_pend   <= 1'b0;
		end else begin
			hresp   <= 1'b0;
			rd_pend <= ahb_ok & ~hwrite;
			wr_pend <= ahb_ok & hwrite;
			if (ahb_ok)
				a_addr <= haddr[7:0];
			hreadyout <= ~(ahb_ok & ~hwrite);
			if (rd_pend)
				hrdata <= rd_data;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			master_enable   <= 1'b0;
			nmi_flag        <= 1'b0;
			addr_error_flag <= 1'b0;
			priority_select <= 2'h0;
			nmi_arm         <= 1'b0;
			ae_arm          <= 1'b0;
		end else begin
			if (gl_wr) begin
				master_enable   <= hwdata[`GOC_DME];
				priority_select <= hwdata[`GOC_PR+1 -: 2];
			end
			// hardware set wins over a software clear in the same cycle
			nmi_flag <= nmi_event | (nmi_flag & ~(gl_wr & nmi_arm & ~hwdata[`GOC_NMI]));
			addr_error_flag <= addr_error
				| (addr_error_flag & ~(gl_wr & ae_arm & ~hwdata[`GOC_AE]));
			if (gl_wr)
				nmi_arm <= 1'b0;
			else if (gl_rd && nmi_flag)
				nmi_arm <= 1'b1;
			if (gl_wr)
				ae_arm <= 1'b0;
			else if (gl_rd && addr_error_flag)
				ae_arm <= 1'b1;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg                  <= ST_IDLE;
			g_reg                      <= 2'h0;
			rot_reg                    <= `ORDER_PR0;
			xfer_req                   <= 1'b0;
			xfer_fetch                 <= 1'b0;
			xfer_chan                  <= 2'h0;
			xfer_size                  <= 2'h0;
			xfer_src                   <= 32'h00000000;
			xfer_dst                   <= 32'h00000000;
			request_acknowledge_strobe <= 1'b0;
			xfer_ack_to_device         <= 1'b0;
			periph_withdraw            <= {NPER{1'b0}};
			periph_irq                 <= {NPER{1'b0}};
			transfer_end_interrupt     <= 4'h0;
		end else begin
			periph_irq <= periph_req & ~consumed;
			for (m = 0; m < 4; m = m + 1)
				transfer_end_interrupt[m] <= ctl_w[m*32 + `CTL_TE] & ctl_w[m*32 + `CTL_IE];
			periph_withdraw <= {NPER{1'b0}};
			if (unit_end && priority_select == `PR_ROTATE)
				rot_reg <= rot_next;
			if (unit_end && g_rs_p && burst_w[g_reg] && g_last)
				periph_withdraw <= {{(NPER-1){1'b0}}, 1'b1} << g_pidx[2:0];
			if (launch) begin
				g_reg      <= l_ch;
				state_reg  <= l_ctl[`CTL_IND] ? ST_IND : ST_MOVE;
				xfer_req   <= 1'b1;
				xfer_fetch <= l_ctl[`CTL_IND];
				xfer_chan  <= l_ch;
				xfer_size  <= l_ctl[`CTL_TS+1 -: 2];
				xfer_src   <= cont ? srcn_w[l_ch*32 +: 32] : src_w[l_ch*32 +: 32];
				xfer_dst   <= cont ? dstn_w[l_ch*32 +: 32] : dst_w[l_ch*32 +: 32];
				request_acknowledge_strobe <= (l_rs == `RS_TO_ACK) | (l_rs == `RS_FROM_ACK);
				xfer_ack_to_device <= (l_rs == `RS_TO_ACK);
				if ((l_rs >= `RS_PERIPH) && !burst_w[l_ch])
					periph_withdraw <= {{(NPER-1){1'b0}}, 1'b1} << l_pidx[2:0];
			end else if (busy && abort) begin
				state_reg  <= ST_IDLE;
				xfer_req   <= 1'b0;
				xfer_fetch <= 1'b0;
				request_acknowledge_strobe <= 1'b0;
			end else if (state_reg == ST_IND && xfer_done) begin
				state_reg  <= ST_MOVE;
				xfer_fetch <= 1'b0;
				xfer_src   <= xfer_rdata;
			end else if (unit_end) begin
				state_reg  <= ST_IDLE;
				xfer_req   <= 1'b0;
				request_acknowledge_strobe <= 1'b0;
			end
		end
	end
endmodule // dma_core

//--- dma_core_props.sv
// concurrent checks on the dma core ports
`timescale 1ns/1ps
module dma_core_props #(
	parameter NPER = 6
) (
	input logic            hclk,
	input logic            hresetn,
	input logic            hsel,
	input logic [1:0]      htrans,
	input logic            hwrite,
	input logic            hready,
	input logic            hreadyout,
	input logic            hresp,
	input logic [31:0]     hrdata,
	input logic            nmi_event,
	input logic            addr_error,
	input logic [NPER-1:0] periph_req,
	input logic [NPER-1:0] periph_withdraw,
	input logic [NPER-1:0] periph_irq,
	input logic            xfer_req,
	input logic            xfer_fetch,
	input logic [1:0]      xfer_chan,
	input logic            request_acknowledge_strobe,
	input logic            xfer_done
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic wr_reg;
	logic wr2_reg;
	// a register write may end a unit up to two edges later
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_reg <= 1'h0;
			wr2_reg <= 1'h0;
		end else begin
			wr_reg <= hsel && hready && htrans[1] && hwrite;
			wr2_reg <= wr_reg;
		end
	end
	sequence s_take;
		hsel && hready && htrans[1];
	endsequence
	sequence s_one_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	a_write_no_wait: assert property (s_take ##0 hwrite |=> hreadyout)
		else $error("write stalled");
	a_read_one_wait: assert property (s_take ##0 !hwrite |=> s_one_wait)
		else $error("read wait wrong");
	a_rdata_holds: assert property (hreadyout |=> $stable(hrdata))
		else $error("read data moved");
	a_resp_okay: assert property (!hresp)
		else $error("error response seen");
	a_nmi_stops_unit: assert property (nmi_event |=> !xfer_req [*2])
		else $error("unit runs after nmi");
	a_aerr_stops_unit: assert property (addr_error |=> !xfer_req)
		else $error("unit runs after address error");
	a_unit_holds: assert property (xfer_req && !xfer_done && !nmi_event
		&& !addr_error && !wr_reg && !wr2_reg |=> xfer_req && $stable(xfer_chan))
		else $error("unit dropped early");
	a_strobe_in_unit: assert property (request_acknowledge_strobe |-> xfer_req)
		else $error("strobe outside unit");
	a_fetch_in_unit: assert property (xfer_fetch |-> xfer_req)
		else $error("fetch outside unit");
	a_withdraw_pulse: assert property (|periph_withdraw |=> !(|periph_withdraw))
		else $error("withdraw not a pulse");
	a_irq_from_req: assert property ((periph_irq & ~$past(periph_req)) == '0)
		else $error("irq without request");
endmodule // dma_core_props

bind dma_core dma_core_props #(.NPER(NPER)) u_dma_core_props (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .nmi_event(nmi_event),
	.addr_error(addr_error), .periph_req(periph_req), .periph_withdraw(periph_withdraw),
	.periph_irq(periph_irq), .xfer_req(xfer_req), .xfer_fetch(xfer_fetch),
	.xfer_chan(xfer_chan), .request_acknowledge_strobe(request_acknowledge_strobe),
	.xfer_done(xfer_done));

//--- xfer_engine_model.sv
// bus engine stand-in that finishes each requested step after a set latency
`timescale 1ns/1ps
module xfer_engine_model (
	input  logic        hclk,
	input  logic        hresetn,
	input  logic        xfer_req,
	input  logic [3:0]  lat,
	output logic        xfer_done,
	output logic [31:0] xfer_rdata
);
	logic [3:0] wait_reg;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_reg <= 4'h0;
			xfer_done <= 1'h0;
			xfer_rdata <= 32'h0;
		end else begin
			xfer_done <= 1'h0;
			// read data is not held outside the done cycle
			xfer_rdata <= ~xfer_rdata;
			if (!xfer_req || xfer_done) begin
				wait_reg <= 4'h0;
			end else if (wait_reg >= lat) begin
				wait_reg <= 4'h0;
				xfer_done <= 1'h1;
				xfer_rdata <= 32'h00002000;
			end else begin
				wait_reg <= wait_reg + 4'h1;
			end
		end
	end
endmodule // xfer_engine_model

//--- test_four_channel_dma_request_priority.sv
// self-checking bench for the four-channel dma core
`timescale 1ns/1ps
module test_four_channel_dma_request_priority;
	logic        hclk = 1'h0;
	logic        hresetn = 1'h0;
	logic        hsel = 1'h0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'h0;
	logic [31:0] hwdata = 32'h0;
	logic        nmi_event = 1'h0;
	logic        addr_error = 1'h0;
	logic [1:0]  ext_n = 2'h3;
	logic [5:0]  periph_req = 6'h0;
	logic [3:0]  lat = 4'h0;
	logic        hready, hresp, xfer_req, xfer_fetch, strobe, to_dev, xfer_done;
	logic [31:0] hrdata, xfer_src, xfer_dst, xfer_rdata, q, src_seen, dst_seen;
	logic [5:0]  withdraw, irq;
	logic [3:0]  tei;
	logic [1:0]  xfer_chan, xfer_size, size_seen;
	logic [7:0]  ord, units, falls, wd_n;
	logic        wd_seen, ack_seen, dir_seen, req_d, fetch_seen;
	int          err_count = 0;
	int          samples_checked = 0;
	always #20 hclk = ~hclk;
	dma_core u_dma_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .nmi_event(nmi_event),
		.addr_error(addr_error), .external_request_line_n(ext_n), .periph_req(periph_req),
		.periph_withdraw(withdraw), .periph_irq(irq), .transfer_end_interrupt(tei),
		.xfer_req(xfer_req), .xfer_fetch(xfer_fetch), .xfer_chan(xfer_chan),
		.xfer_size(xfer_size), .xfer_src(xfer_src), .xfer_dst(xfer_dst),
		.request_acknowledge_strobe(strobe), .xfer_ack_to_device(to_dev),
		.xfer_done(xfer_done), .xfer_rdata(xfer_rdata));
	xfer_engine_model u_xfer_engine_model (.hclk(hclk), .hresetn(hresetn),
		.xfer_req(xfer_req), .lat(lat), .xfer_done(xfer_done), .xfer_rdata(xfer_rdata));
	always @(posedge hclk) begin
		req_d <= xfer_req;
		if (req_d && !xfer_req) falls <= falls + 8'h1;
		if (xfer_req && xfer_done) begin
			ord <= {ord[5:0], xfer_chan};
			units <= units + 8'h1;
			src_seen <= xfer_src;
			dst_seen <= xfer_dst;
			size_seen <= xfer_size;
		end
		if (withdraw[0]) wd_seen <= 1'h1;
		if (|withdraw) wd_n <= wd_n + 8'h1;
		if (xfer_fetch) fetch_seen <= 1'h1;
		if (xfer_req) begin
			ack_seen <= strobe;
			dir_seen <= to_dev;
		end
	end
	task chk(input string n, input [31:0] e, input [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task results;
		if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// hready is judged at the falling edge, where the registered value has settled
	task rdy;
		@(negedge hclk);
		while (hready !== 1'h1) @(negedge hclk);
		q = hrdata;
		@(posedge hclk);
	endtask
	task bus(input w, input [7:0] a, input [31:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		rdy;
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
	endtask
	task rd(input [7:0] a, input [31:0] e);
		bus(1'h0, a, 32'h0);
		chk($sformatf("reg %h", a), e, q);
	endtask
	task wt(input [3:0] m);
		repeat (2000) if ((tei & m) !== m) @(posedge hclk);
	endtask
	// reading the set end flag arms the clear that follows
	task clr(input [7:0] a);
		bus(1'h0, a, 32'h0);
		bus(1'h1, a, 32'h0);
	endtask
	task t_auto;
		bus(1'h1, 8'h40, 32'h1);
		bus(1'h1, 8'h08, 32'h2);
		units <= 8'h0;
		bus(1'h1, 8'h0C, 32'h405);
		wt(4'h1);
		chk("units", 32'h2, units);
		rd(8'h08, 32'h0);
		rd(8'h0C, 32'h407);
		chk("tei", 32'h1, tei);
		bus(1'h1, 8'h0C, 32'h404);
		rd(8'h0C, 32'h404);
	endtask
	task t_abort(input [1:0] k);
		lat <= 4'hA;
		units <= 8'h0;
		bus(1'h1, 8'h08, 32'h3);
		bus(1'h1, 8'h0C, 32'h405);
		repeat (50) if (!xfer_req) @(posedge hclk);
		if (k == 2'h2) bus(1'h1, 8'h40, 32'h0);
		else if (k == 2'h1) addr_error <= 1'h1;
		else nmi_event <= 1'h1;
		@(posedge hclk);
		nmi_event <= 1'h0;
		addr_error <= 1'h0;
		// outlast the engine latency so a missed abort would finish a unit
		repeat (16) @(posedge hclk);
		rd(8'h40, k == 2'h2 ? 32'h0 : k == 2'h1 ? 32'h5 : 32'h3);
		rd(8'h08, 32'h3);
		rd(8'h0C, 32'h405);
		chk("units", 32'h0, units);
		lat <= 4'h0;
		bus(1'h1, 8'h40, 32'h1);
		wt(4'h1);
		chk("units", 32'h3, units);
		clr(8'h0C);
	endtask
	task t_arb(input [1:0] pr, input [1:0] ca, input [1:0] cb, input [31:0] n,
		input [7:0] e);
		bus(1'h1, 8'h40, 32'h0);
		bus(1'h1, {2'h0, ca, 4'h8}, n);
		bus(1'h1, {2'h0, ca, 4'hC}, 32'h405);
		bus(1'h1, {2'h0, cb, 4'h8}, n);
		bus(1'h1, {2'h0, cb, 4'hC}, 32'h405);
		ord <= 8'h0;
		bus(1'h1, 8'h40, {22'h0, pr, 8'h01});
		wt((4'h1 << ca) | (4'h1 << cb));
		chk("order", e, ord);
		clr({2'h0, ca, 4'hC});
		clr({2'h0, cb, 4'hC});
	endtask
	task t_periph;
		periph_req <= 6'h01;
		wd_seen <= 1'h0;
		rd(8'h1C, 32'h0);
		chk("irq", 32'h1, irq);
		bus(1'h1, 8'h18, 32'h1);
		bus(1'h1, 8'h14, 32'h00000F00);
		bus(1'h1, 8'h1C, 32'hA05);
		wt(4'h2);
		chk("irq", 32'h0, irq);
		chk("withdraw", 32'h1, wd_seen);
		periph_req <= 6'h0;
		clr(8'h1C);
	endtask
	// timer request in burst: one train of units, withdrawn after the last one only
	task t_burst;
		periph_req <= 6'h20;
		units <= 8'h0;
		falls <= 8'h0;
		wd_n <= 8'h0;
		bus(1'h1, 8'h20, 32'h100);
		bus(1'h1, 8'h24, 32'h200);
		bus(1'h1, 8'h28, 32'h2);
		bus(1'h1, 8'h2C, 32'h9F35);
		wt(4'h4);
		chk("units", 32'h2, units);
		chk("falls", 32'h1, falls);
		chk("withdraws", 32'h1, wd_n);
		chk("size", 32'h2, size_seen);
		chk("src", 32'h104, src_seen);
		chk("dst", 32'h1FC, dst_seen);
		rd(8'h20, 32'h108);
		rd(8'h24, 32'h1F8);
		periph_req <= 6'h0;
		clr(8'h2C);
	endtask
	// the engine model answers the address fetch with 2000
	task t_ind;
		fetch_seen <= 1'h0;
		bus(1'h1, 8'h20, 32'h300);
		bus(1'h1, 8'h28, 32'h1);
		bus(1'h1, 8'h2C, 32'h100415);
		wt(4'h4);
		chk("fetch", 32'h1, fetch_seen);
		chk("src", 32'h2000, src_seen);
		rd(8'h28, 32'h0);
		clr(8'h2C);
	endtask
	task t_ext(input [3:0] rs, input ds);
		bus(1'h1, 8'h08, 32'h1);
		bus(1'h1, 8'h0C, {20'h0, rs, 1'h0, ds, 6'h05});
		ext_n <= 2'h2;
		if (ds) begin
			@(posedge hclk);
			ext_n <= 2'h3;
		end
		wt(4'h1);
		ext_n <= 2'h3;
		chk("tei", 32'h1, tei);
		chk("strobe", rs != 4'h0, ack_seen);
		chk("to device", rs == 4'h2, dir_seen);
		clr(8'h0C);
	endtask
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		rd(8'h40, 32'h0);
		rd(8'h0C, 32'h0);
		rd(8'h50, 32'h0);
		t_auto;
		t_abort(2'h0);
		t_abort(2'h1);
		t_abort(2'h2);
		t_arb(2'h0, 2'h0, 2'h3, 32'h2, 8'h0F);
		t_arb(2'h1, 2'h1, 2'h3, 32'h1, 8'h0D);
		t_arb(2'h2, 2'h0, 2'h2, 32'h1, 8'h08);
		t_arb(2'h3, 2'h0, 2'h3, 32'h2, 8'h33);
		t_periph;
		t_burst;
		t_ind;
		t_ext(4'h0, 1'h0);
		t_ext(4'h2, 1'h1);
		t_ext(4'h3, 1'h0);
		results;
	end
	initial begin
		#400000;
		err_count++;
		results;
	end
endmodule // test_four_channel_dma_request_priority
